// ---- design/omc_cfg.svh ----
// Constants for the operating mode controller
`ifndef OMC_CFG_SVH
`define OMC_CFG_SVH

`define OMC_RESET_VECTOR       16'hFFFE
`define OMC_AV_ADDR_W          4
// Register byte offsets
`define OMC_REG_CTRL           4'h0
`define OMC_REG_STATUS         4'h4
`define OMC_REG_CMD            4'h8
`define OMC_REG_RESULT         4'hC
// Control field positions
`define OMC_CTRL_HALT_ALLOW    0
`define OMC_CTRL_DEBUG_EN      1
`define OMC_CTRL_BO_EN         2
`define OMC_CTRL_BO_HALT_EN    3
`define OMC_CTRL_DEEP_PD       4
`define OMC_CTRL_PART_PD       5
`define OMC_CTRL_RESET         32'h0000_0000
// Result codes for debug commands
`define OMC_RES_OK             2'h0
`define OMC_RES_SLEEP_ERR      2'h1
`define OMC_RES_REFUSED        2'h2

`endif

// ---- design/omc_pkg.sv ----
// Types for the operating mode controller
`default_nettype none
package omc_pkg;
  typedef enum logic [2:0] {
    OMC_RUN   = 3'h0,
    OMC_SLEEP = 3'h1,
    OMC_HALT  = 3'h3,
    OMC_DEBUG = 3'h2
  } omc_mode_t;

  typedef enum logic [1:0] {
    OMC_LVL_NONE  = 2'h0,
    OMC_LVL_SHALLOW = 2'h1,
    OMC_LVL_PART  = 2'h3,
    OMC_LVL_FULL  = 2'h2
  } omc_level_t;

  typedef enum logic [2:0] {
    OMC_CMD_MEM      = 3'h0,
    OMC_CMD_MEM_STAT = 3'h1,
    OMC_CMD_CTRL_REG = 3'h2,
    OMC_CMD_HALT_DBG = 3'h3,
    OMC_CMD_CPU_REG  = 3'h4,
    OMC_CMD_TRACE    = 3'h5,
    OMC_CMD_RESUME   = 3'h6
  } omc_cmd_t;
endpackage : omc_pkg
`default_nettype wire

// ---- design/omc_ctrl.sv ----
// Operating mode controller: run, sleep, halt levels and debug-halted mode
//
// Overview of operation
// - Reset release with mode pin high enters run, fetching vector at 0xFFFE:0xFFFF.
// - Mode pin low at power-on, or debug-forced reset, enters debug-halted mode.
// - Halt command, debug instruction, or either breakpoint also enter debug-halted.
// - Debug-halted mode stops user instruction fetch and awaits debug commands.
// - Memory, status memory, controller register and halt commands work in run and debug.
// - CPU register, trace and resume commands work only in debug-halted mode.
// - Sleep instruction stops CPU clock; system clocks and regulation stay on.
// - Entering sleep clears the interrupt mask bit.
// - Any interrupt wakes sleep and resumes with interrupt stacking.
// - In sleep only halt and status-memory commands; status returns sleeping error.
// - Halt command during sleep wakes straight into debug-halted mode.
// - Halt instruction with halt-allow clear gives illegal-opcode reset.
// - Halt allowed and debug enabled: shallowest level, debug clocks running.
// - Debug off, both brownout bits set: shallowest level, regulator active.
// - Otherwise deep 0 shallow, deep 1 partial 1 partial, deep 1 partial 0 full.
// - Every halt level stops bus and CPU clocks.
// - Shallowest level keeps all state, RAM and pins unchanged.
// - Shallowest level left by reset pin or timer, brownout, ADC, pin, keypad interrupt.
// - Reset-pin wake resets and fetches reset vector; interrupt wake fetches its vector.
// - Both brownout bits set at halt keeps regulator active throughout.
// - Debug enable at halt keeps debug clocks and full regulation.
// - Halt with debug: halt command wakes to debug; status commands report halted (code returns the sleeping-error result here, as in sleep).
//
// Added by the designer: register access over Avalon-MM and the address map.
`include "omc_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module omc_ctrl (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        por_i,
  input  wire logic        dbg_force_rst_i,
  // Pins (asynchronous)
  input  wire logic        mode_select_debug_pin_i,
  input  wire logic        reset_pin_n_i,
  // Core events (synchronous pulses)
  input  wire logic        sleep_instr_i,
  input  wire logic        halt_instr_i,
  input  wire logic        debug_entry_instruction_i,
  input  wire logic        bdc_breakpoint_i,
  input  wire logic        breakpoint_unit_i,
  input  wire logic        irq_any_i,
  input  wire logic        wake_rti_i,
  input  wire logic        wake_brownout_i,
  input  wire logic        wake_adc_i,
  input  wire logic        wake_ext_pin_i,
  input  wire logic        wake_keypad_i,
  // Debug command strobe from serial debug controller
  input  wire logic        dbg_cmd_valid_i,
  input  wire logic [2:0]  dbg_cmd_i,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Mode outputs
  output logic             run_mode_o,
  output logic             debug_halted_o,
  output logic             fetch_en_o,
  output logic [15:0]      fetch_vector_o,
  output logic             fetch_vector_valid_o,
  output logic             cpu_clk_en_o,
  output logic             bus_clk_en_o,
  output logic             debug_clk_en_o,
  output logic             regulator_full_o,
  output logic [1:0]       halt_level_o,
  output logic             clr_irq_mask_o,
  output logic             irq_stack_o,
  output logic             illegal_op_rst_o,
  output logic             hold_state_o,
  output logic             dbg_cmd_accept_o,
  output logic             dbg_mem_access_o,
  output logic [1:0]       dbg_result_o,
  output logic             dbg_result_valid_o
);

  // Pin synchronisers
  logic [1:0] ms_sync_r;
  logic [1:0] rpin_sync_r;
  always_ff @(posedge clk_sys_i) begin
    ms_sync_r   <= {ms_sync_r[0], mode_select_debug_pin_i};
    rpin_sync_r <= {rpin_sync_r[0], reset_pin_n_i};
  end
  wire ms_pin_s   = ms_sync_r[1];
  wire rpin_low_s = ~rpin_sync_r[1];

  // Registers
  logic [31:0]        ctrl_r;
  omc_pkg::omc_mode_t mode_r, mode_nxt;
  omc_pkg::omc_level_t level_r, level_nxt;
  logic               lvl_dbg_r, lvl_reg_r;
  logic               strap_pend_r;
  logic               ack_r;

  wire ha  = ctrl_r[`OMC_CTRL_HALT_ALLOW];
  wire den = ctrl_r[`OMC_CTRL_DEBUG_EN];
  wire bo_both = ctrl_r[`OMC_CTRL_BO_EN] & ctrl_r[`OMC_CTRL_BO_HALT_EN];
  wire dp  = ctrl_r[`OMC_CTRL_DEEP_PD];
  wire pp  = ctrl_r[`OMC_CTRL_PART_PD];

  // Halt level from the control bits at the halt instruction
  function automatic omc_pkg::omc_level_t pick_level(input logic d, input logic b,
                                                     input logic deep, input logic part);
    if (d || b || !deep)
      pick_level = omc_pkg::OMC_LVL_SHALLOW;
    else if (part)
      pick_level = omc_pkg::OMC_LVL_PART;
    else
      pick_level = omc_pkg::OMC_LVL_FULL;
  endfunction : pick_level

  // Command classes
  wire cmd_halt     = dbg_cmd_valid_i && (dbg_cmd_i == omc_pkg::OMC_CMD_HALT_DBG);
  wire cmd_memstat  = dbg_cmd_i == omc_pkg::OMC_CMD_MEM_STAT;
  wire cmd_nonintr  = dbg_cmd_i <= omc_pkg::OMC_CMD_HALT_DBG;
  wire cmd_active   = (dbg_cmd_i >= omc_pkg::OMC_CMD_CPU_REG) &&
                      (dbg_cmd_i <= omc_pkg::OMC_CMD_RESUME);
  wire cmd_resume   = dbg_cmd_valid_i && (dbg_cmd_i == omc_pkg::OMC_CMD_RESUME);

  wire in_run   = mode_r == omc_pkg::OMC_RUN;
  wire in_debug = mode_r == omc_pkg::OMC_DEBUG;
  wire in_sleep = mode_r == omc_pkg::OMC_SLEEP;
  wire in_halt  = mode_r == omc_pkg::OMC_HALT;
  wire halt_dbg = in_halt && lvl_dbg_r;

  wire accept_w = dbg_cmd_valid_i && (
                    ((in_run || in_debug) && cmd_nonintr) ||
                    (in_debug && cmd_active) ||
                    ((in_sleep || halt_dbg) && (cmd_halt || cmd_memstat)));
  wire memacc_w = accept_w && (in_run || in_debug) &&
                  ((dbg_cmd_i == omc_pkg::OMC_CMD_MEM) || cmd_memstat);
  wire sleep_err_w = accept_w && cmd_memstat && (in_sleep || in_halt);

  wire shallow_wake = wake_rti_i | wake_brownout_i | wake_adc_i |
                      wake_ext_pin_i | wake_keypad_i;
  wire dbg_entry = cmd_halt | debug_entry_instruction_i |
                   bdc_breakpoint_i | breakpoint_unit_i;
  wire illegal_w = in_run && halt_instr_i && !ha;

  // Mode transitions
  always_comb begin
    mode_nxt  = mode_r;
    level_nxt = level_r;
    unique case (mode_r)
      omc_pkg::OMC_RUN: begin
        if (dbg_entry) begin
          mode_nxt = omc_pkg::OMC_DEBUG;
        end else if (halt_instr_i && ha) begin
          mode_nxt  = omc_pkg::OMC_HALT;
          level_nxt = pick_level(den, bo_both, dp, pp);
        end else if (sleep_instr_i) begin
          mode_nxt = omc_pkg::OMC_SLEEP;
        end
      end
      omc_pkg::OMC_SLEEP: begin
        if (cmd_halt)
          mode_nxt = omc_pkg::OMC_DEBUG;
        else if (irq_any_i)
          mode_nxt = omc_pkg::OMC_RUN;
      end
      omc_pkg::OMC_HALT: begin
        if (halt_dbg && cmd_halt) begin
          mode_nxt  = omc_pkg::OMC_DEBUG;
          level_nxt = omc_pkg::OMC_LVL_NONE;
        end else if (level_r == omc_pkg::OMC_LVL_SHALLOW && shallow_wake) begin
          mode_nxt  = omc_pkg::OMC_RUN;
          level_nxt = omc_pkg::OMC_LVL_NONE;
        end
      end
      omc_pkg::OMC_DEBUG: begin
        if (cmd_resume)
          mode_nxt = omc_pkg::OMC_RUN;
      end
      default: mode_nxt = omc_pkg::OMC_RUN;
    endcase
  end

  // Bus decode
  // A write lands only at the edge where waitrequest is seen low by the master
  wire bus_wr  = avs_write && ack_r;
  wire bus_rd  = avs_read && !ack_r;
  wire sel_ctl = avs_address == `OMC_REG_CTRL;
  wire sel_st  = avs_address == `OMC_REG_STATUS;
  wire [31:0] rd_mux =
    sel_ctl ? ctrl_r :
    sel_st  ? {24'h00_0000, lvl_reg_r, lvl_dbg_r, level_r, 1'b0, mode_r} :
    32'h0000_0000;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ack_r           <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      ack_r           <= (avs_read || avs_write) && !ack_r;
      avs_waitrequest <= !((avs_read || avs_write) && !ack_r);
      avs_readdata    <= bus_rd ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i)
      ctrl_r <= `OMC_CTRL_RESET;
    else if (bus_wr && sel_ctl)
      ctrl_r <= {26'h000_0000, avs_writedata[5:0]};
  end

  // Strap capture: mode pin read once reset has released
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      strap_pend_r <= 1'b1;
    end else begin
      strap_pend_r <= 1'b0;
    end
  end

  // Reset-pin wake from shallow halt is handled as a reset: mode registers cleared, reset-vector fetch flagged
  wire pin_reset_w = in_halt && level_r == omc_pkg::OMC_LVL_SHALLOW && rpin_low_s;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || pin_reset_w) begin
      mode_r    <= omc_pkg::OMC_RUN;
      level_r   <= omc_pkg::OMC_LVL_NONE;
      lvl_dbg_r <= 1'b0;
      lvl_reg_r <= 1'b0;
    end else if (strap_pend_r) begin
      // Power-on strap low or a forced reset lands in debug
      mode_r <= ((por_i && !ms_pin_s) || dbg_force_rst_i) ?
                omc_pkg::OMC_DEBUG : omc_pkg::OMC_RUN;
    end else begin
      mode_r  <= mode_nxt;
      level_r <= level_nxt;
      if (in_run && halt_instr_i && ha) begin
        lvl_dbg_r <= den;
        lvl_reg_r <= den | bo_both;
      end
    end
  end

  // Outputs, all registered
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      run_mode_o           <= 1'b0;
      debug_halted_o       <= 1'b0;
      fetch_en_o           <= 1'b0;
      fetch_vector_o       <= 16'h0000;
      fetch_vector_valid_o <= 1'b0;
      cpu_clk_en_o         <= 1'b0;
      bus_clk_en_o         <= 1'b0;
      debug_clk_en_o       <= 1'b0;
      regulator_full_o     <= 1'b1;
      halt_level_o         <= 2'h0;
      clr_irq_mask_o       <= 1'b0;
      irq_stack_o          <= 1'b0;
      illegal_op_rst_o     <= 1'b0;
      hold_state_o         <= 1'b0;
      dbg_cmd_accept_o     <= 1'b0;
      dbg_mem_access_o     <= 1'b0;
      dbg_result_o         <= 2'h0;
      dbg_result_valid_o   <= 1'b0;
    end else begin
      run_mode_o           <= mode_r == omc_pkg::OMC_RUN;
      debug_halted_o       <= mode_r == omc_pkg::OMC_DEBUG;
      fetch_en_o           <= mode_r == omc_pkg::OMC_RUN;
      fetch_vector_o       <= `OMC_RESET_VECTOR;
      fetch_vector_valid_o <= (strap_pend_r && !((por_i && !ms_pin_s) || dbg_force_rst_i))
                              || pin_reset_w;
      cpu_clk_en_o         <= mode_r == omc_pkg::OMC_RUN;
      bus_clk_en_o         <= !in_halt;
      debug_clk_en_o       <= !in_halt || lvl_dbg_r;
      regulator_full_o     <= !in_halt || lvl_reg_r;
      halt_level_o         <= level_r;
      clr_irq_mask_o       <= in_run && mode_nxt == omc_pkg::OMC_SLEEP;
      irq_stack_o          <= (in_sleep && mode_nxt == omc_pkg::OMC_RUN) ||
                              (in_halt && mode_nxt == omc_pkg::OMC_RUN);
      illegal_op_rst_o     <= illegal_w;
      hold_state_o         <= in_halt && level_r == omc_pkg::OMC_LVL_SHALLOW;
      dbg_cmd_accept_o     <= accept_w;
      dbg_mem_access_o     <= memacc_w;
      dbg_result_o         <= !dbg_cmd_valid_i ? `OMC_RES_OK :
                              sleep_err_w ? `OMC_RES_SLEEP_ERR :
                              accept_w ? `OMC_RES_OK : `OMC_RES_REFUSED;
      dbg_result_valid_o   <= dbg_cmd_valid_i;
    end
  end

endmodule : omc_ctrl
`default_nettype wire

// ---- test/omc_ctrl_asserts.sv ----
// Checker bound to the operating mode controller
`timescale 1ns/1ns
`default_nettype none
module omc_ctrl_asserts (
  // Clock, reset and inputs
  input wire logic       clk_sys_i,
  input wire logic       rst_i,
  input wire logic       sleep_instr_i,
  input wire logic       irq_any_i,
  input wire logic       dbg_cmd_valid_i,
  input wire logic [2:0] dbg_cmd_i,
  // Outputs watched
  input wire logic       run_mode_o,
  input wire logic       debug_halted_o,
  input wire logic       fetch_en_o,
  input wire logic       cpu_clk_en_o,
  input wire logic       bus_clk_en_o,
  input wire logic       regulator_full_o,
  input wire logic [1:0] halt_level_o,
  input wire logic       clr_irq_mask_o,
  input wire logic       irq_stack_o,
  input wire logic       hold_state_o,
  input wire logic       dbg_cmd_accept_o,
  input wire logic [1:0] dbg_result_o,
  input wire logic       dbg_result_valid_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // A command right behind another may see a stale run flag, so it is left out
  a_result_one_cycle: assert property (dbg_cmd_valid_i |=> dbg_result_valid_o)
    else $error("debug result not one cycle after command");
  a_refuse_in_run: assert property (dbg_cmd_valid_i && dbg_cmd_i >= 3'h4 && run_mode_o
    && !$past(dbg_cmd_valid_i) |=> !dbg_cmd_accept_o && dbg_result_o == 2'h2)
    else $error("halted-only command not refused in run");
  a_sleep_clocks: assert property (sleep_instr_i && run_mode_o && !dbg_cmd_valid_i
    |-> ##2 !cpu_clk_en_o && bus_clk_en_o && regulator_full_o)
    else $error("sleep clock gating wrong");
  a_mask_cleared: assert property (sleep_instr_i && run_mode_o && !dbg_cmd_valid_i
    |-> ##[1:2] clr_irq_mask_o)
    else $error("interrupt mask not cleared on sleep");
  a_irq_wakes: assert property (irq_any_i && !cpu_clk_en_o && bus_clk_en_o && !debug_halted_o
    && halt_level_o == 2'h0 && !irq_stack_o |-> ##[1:3] irq_stack_o)
    else $error("interrupt did not wake sleep");
  a_halt_clocks_off: assert property (halt_level_o != 2'h0 |-> !cpu_clk_en_o && !bus_clk_en_o)
    else $error("clocks running in halt");
  a_level_held: assert property (halt_level_o != 2'h0 && $past(halt_level_o) != 2'h0
    |-> halt_level_o == $past(halt_level_o))
    else $error("halt level changed during halt");
  a_shallow_hold: assert property (halt_level_o == 2'h1 |-> hold_state_o)
    else $error("state not held in shallow halt");
  a_no_user_fetch: assert property (debug_halted_o |-> !fetch_en_o && !run_mode_o)
    else $error("fetching while debug halted");
  c_partial: cover property (halt_level_o == 2'h3);
  c_debug: cover property ($rose(debug_halted_o));
  c_irq_wake: cover property (irq_stack_o);
endmodule : omc_ctrl_asserts
bind omc_ctrl omc_ctrl_asserts chk_u (.*);
`default_nettype wire

// ---- test/omc_dbg_host.sv ----
// Behavioural debug host on the mode pin and command strobe
`timescale 1ns/1ns
`default_nettype none
module omc_dbg_host (
  // Clock
  input wire logic       clk_i,
  // Towards the controller
  output logic           pin_o,
  output logic           valid_o,
  output logic     [2:0] cmd_o,
  // Answers
  input wire logic       acc_i,
  input wire logic       rv_i,
  input wire logic [1:0] res_i,
  input wire logic       mem_i
);
  initial begin
    pin_o = 1'b1;
    valid_o = 1'b0;
    cmd_o = 3'h7;
  end
  task set_pin(input logic v);
    pin_o <= v;
  endtask : set_pin
  // Idle command lines toggle so a stale code is never mistaken for a live one
  task send(input logic [2:0] c, output logic a, output logic [1:0] r, output logic m);
    @(posedge clk_i);
    valid_o <= 1'b1;
    cmd_o <= c;
    @(posedge clk_i);
    valid_o <= 1'b0;
    cmd_o <= ~c;
    @(negedge clk_i);
    a = acc_i & rv_i;
    r = res_i;
    m = mem_i;
    @(posedge clk_i);
  endtask : send
endmodule : omc_dbg_host
`default_nettype wire

// ---- test/omc_ctrl_tb_top.sv ----
// Testbench for the operating mode controller
`timescale 1ns/1ns
`default_nettype none
module omc_ctrl_tb_top;
  logic clk_sys_i = 0, rst_i = 1, por_i = 1, dfr = 0, clr = 0, irq = 0, rd = 0, wr = 0, a, m;
  logic [4:0] ev = 0, wk = 0;
  logic [3:0] adr = 0, seen = 0;
  logic [31:0] wd = 0, rdata, avs_rd;
  logic [15:0] fvec;
  logic [1:0] lvl, res, r;
  logic wq, run, dbgh, fen, fvv, cpuc, busc, dclk, regf, clrm, stk, ill, hold, acc, mem, rv;
  logic pin, cv;
  logic rpn = 1;
  logic [2:0] cmd;
  int n_fail = 0, checks_done = 0;
  logic [5:0] cfg [5] = '{6'h33, 6'h3D, 6'h01, 6'h31, 6'h11};
  logic [1:0] exl [5] = '{2'h1, 2'h1, 2'h1, 2'h3, 2'h2};
  always #10 clk_sys_i = ~clk_sys_i;
  // Short output pulses are caught here and cleared per test
  always @(posedge clk_sys_i) seen <= clr ? 4'h0 : seen | {fvv, clrm, stk, ill};
  omc_dbg_host host_u (.clk_i(clk_sys_i), .pin_o(pin), .valid_o(cv), .cmd_o(cmd), .acc_i(acc),
    .rv_i(rv), .res_i(res), .mem_i(mem));
  omc_ctrl dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .por_i(por_i), .dbg_force_rst_i(dfr),
    .mode_select_debug_pin_i(pin), .reset_pin_n_i(rpn), .sleep_instr_i(ev[0]),
    .halt_instr_i(ev[1]), .debug_entry_instruction_i(ev[2]), .bdc_breakpoint_i(ev[3]),
    .breakpoint_unit_i(ev[4]), .irq_any_i(irq), .wake_rti_i(wk[0]), .wake_brownout_i(wk[1]),
    .wake_adc_i(wk[2]), .wake_ext_pin_i(wk[3]), .wake_keypad_i(wk[4]), .dbg_cmd_valid_i(cv),
    .dbg_cmd_i(cmd), .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_readdata(avs_rd), .avs_waitrequest(wq), .run_mode_o(run), .debug_halted_o(dbgh),
    .fetch_en_o(fen), .fetch_vector_o(fvec), .fetch_vector_valid_o(fvv), .cpu_clk_en_o(cpuc),
    .bus_clk_en_o(busc), .debug_clk_en_o(dclk), .regulator_full_o(regf), .halt_level_o(lvl),
    .clr_irq_mask_o(clrm), .irq_stack_o(stk), .illegal_op_rst_o(ill), .hold_state_o(hold),
    .dbg_cmd_accept_o(acc), .dbg_mem_access_o(mem), .dbg_result_o(res),
    .dbg_result_valid_o(rv));
  task tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : tick
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task bus(input logic w, input logic [3:0] ad, input logic [31:0] d);
    @(posedge clk_sys_i);
    rd <= !w;
    wr <= w;
    adr <= ad;
    wd <= d;
    do begin
      @(posedge clk_sys_i);
    end while (wq !== 1'b0);
    rdata = avs_rd;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task pulse(input int i);
    ev[i] <= 1'b1;
    tick(1);
    ev[i] <= 1'b0;
    tick(3);
  endtask : pulse
  task reset(input logic p, input logic f, input logic pn);
    rst_i <= 1'b1;
    clr <= 1'b1;
    por_i <= p;
    dfr <= f;
    host_u.set_pin(pn);
    tick(3);
    rst_i <= 1'b0;
    clr <= 1'b0;
    tick(1);
    por_i <= 1'b0;
    dfr <= 1'b0;
    tick(4);
  endtask : reset
  task results;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  initial begin
    tick(5000);
    n_fail++;
    results;
  end
  initial begin
    reset(1'b1, 1'b0, 1'b1);
    chk("run", run, 1);
    chk("vector", fvec, 16'hFFFE);
    chk("vector_pulse", seen[3], 1);
    bus(0, 4'h0, 0);
    chk("ctrl_reset", rdata, 0);
    bus(1, 4'h1, 32'h0000_FFFF);
    bus(0, 4'h1, 0);
    chk("unmapped", rdata, 0);
    for (int c = 0; c < 7; c++) if (c != 3) begin
      host_u.send(c[2:0], a, r, m);
      chk("accept_run", a, c < 3);
      chk("result_run", r, c < 3 ? 2'h0 : 2'h2);
    end
    host_u.send(3'h3, a, r, m);
    tick(2);
    chk("halt_cmd", dbgh, 1);
    chk("no_fetch", fen, 0);
    bus(0, 4'h4, 0);
    chk("status_dbg", rdata[2:0], 3'h2);
    for (int c = 4; c < 7; c++) begin
      host_u.send(c[2:0], a, r, m);
      chk("accept_dbg", a, 1);
    end
    tick(2);
    chk("resume", run, 1);
    $display("test commands done");
    for (int i = 2; i < 5; i++) begin
      pulse(i);
      chk("entry_path", dbgh, 1);
      host_u.send(3'h6, a, r, m);
      tick(2);
    end
    reset(1'b1, 1'b0, 1'b0);
    chk("strap_low", dbgh, 1);
    reset(1'b0, 1'b1, 1'b1);
    chk("forced", dbgh, 1);
    reset(1'b1, 1'b0, 1'b1);
    pulse(0);
    chk("cpu_clk", cpuc, 0);
    chk("sys_clk", busc & regf, 1);
    chk("mask_clr", seen[2], 1);
    host_u.send(3'h1, a, r, m);
    chk("sleep_stat", r, 2'h1);
    chk("sleep_mem", m, 0);
    host_u.send(3'h0, a, r, m);
    chk("sleep_mem_cmd", r, 2'h2);
    irq <= 1'b1;
    tick(3);
    irq <= 1'b0;
    tick(2);
    chk("irq_stack", seen[1], 1);
    chk("irq_run", run, 1);
    pulse(0);
    host_u.send(3'h3, a, r, m);
    tick(2);
    chk("sleep_halt", dbgh, 1);
    host_u.send(3'h6, a, r, m);
    tick(2);
    pulse(1);
    chk("illegal", seen[0], 1);
    $display("test sleep done");
    for (int i = 0; i < 5; i++) begin
      reset(1'b0, 1'b0, 1'b1);
      bus(1, 4'h0, {26'h0, cfg[i]});
      pulse(1);
      chk("level", lvl, exl[i]);
      chk("bus_clk", busc, 0);
      chk("dbg_clk", dclk, i == 0);
      chk("regulator", regf, i < 2);
      if (i == 0) begin
        host_u.send(3'h1, a, r, m);
        chk("halt_stat", r, 2'h1);
        host_u.send(3'h3, a, r, m);
        tick(2);
        chk("halt_dbg", dbgh, 1);
      end else if (i < 3) begin
        wk[i + 1] <= 1'b1;
        tick(1);
        wk[i + 1] <= 1'b0;
        tick(4);
        chk("wake", run, 1);
      end
    end
    reset(1'b0, 1'b0, 1'b1);
    bus(1, 4'h0, 32'h0000_0001);
    pulse(1);
    clr <= 1'b1;
    tick(1);
    clr <= 1'b0;
    rpn <= 1'b0;
    tick(4);
    rpn <= 1'b1;
    tick(4);
    chk("pin_wake", run, 1);
    chk("pin_vector", seen[3], 1);
    $display("test halt done");
    results;
  end
endmodule : omc_ctrl_tb_top
`default_nettype wire
